// ### rtl/sbc_regmap_pkg.sv
// Shared types and constants for the SPI register bank of the system basis chip
package sbc_regmap_pkg;

    // ------------------------------------------------------------------
    // Operating modes and frame states
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        MODE_INIT = 3'h0,
        MODE_NORMAL = 3'h1,
        MODE_STOP = 3'h3,
        MODE_SLEEP = 3'h2,
        MODE_RESTART = 3'h6,
        MODE_FAIL_SAFE = 3'h7
    } op_mode_t;

    typedef enum logic [1:0]
    {
        FR_IDLE = 2'h0,
        FR_SHIFT = 2'h1,
        FR_END = 2'h3
    } frame_state_t;

    // ------------------------------------------------------------------
    // Frame layout and register banks
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0] data;
        logic rw;
        logic [6:0] addr;
    } spi_frame_t;

    localparam int CTRL_COUNT = 10;
    localparam int STAT_COUNT = 8;
    typedef logic [CTRL_COUNT-1:0][7:0] ctrl_bank_t;
    typedef logic [STAT_COUNT-1:0][7:0] stat_bank_t;
    typedef struct packed
    {
        logic hit;
        logic [3:0] idx;
    } reg_sel_t;

    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] HALF_FRAME_BITS = 5'h08;
    localparam logic [4:0] BIT_COUNT_MAX = 5'h1F;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_MODE_SUPPLY_CONTROL = 7'h01;
    localparam logic [6:0] ADDR_HARDWARE_CONTROL = 7'h02;
    localparam logic [6:0] ADDR_WATCHDOG_CONTROL = 7'h03;
    localparam logic [6:0] ADDR_BUS_CONTROL_ONE = 7'h04;
    localparam logic [6:0] ADDR_BUS_CONTROL_TWO = 7'h05;
    localparam logic [6:0] ADDR_WAKE_CONTROL_ONE = 7'h06;
    localparam logic [6:0] ADDR_WAKE_CONTROL_TWO = 7'h07;
    localparam logic [6:0] ADDR_WAKE_PULL_CONTROL = 7'h08;
    localparam logic [6:0] ADDR_CYCLIC_TIMER_CONTROL = 7'h0C;
    localparam logic [6:0] ADDR_SYSTEM_SCRATCH_CONTROL = 7'h1E;
    localparam logic [6:0] ADDR_SUPPLY_STATUS = 7'h41;
    localparam logic [6:0] ADDR_THERMAL_STATUS = 7'h42;
    localparam logic [6:0] ADDR_DEVICE_STATUS = 7'h43;
    localparam logic [6:0] ADDR_BUS_STATUS_ONE = 7'h44;
    localparam logic [6:0] ADDR_BUS_STATUS_TWO = 7'h45;
    localparam logic [6:0] ADDR_WAKE_STATUS_ONE = 7'h46;
    localparam logic [6:0] ADDR_WAKE_STATUS_TWO = 7'h47;
    localparam logic [6:0] ADDR_WAKE_LEVEL_STATUS = 7'h48;
    localparam logic [6:0] ADDR_SWITCHER_STATUS = 7'h4C;
    localparam logic [6:0] ADDR_PRODUCT_IDENTIFICATION = 7'h7E;

    // Bank indexes of control registers that the logic steers
    localparam logic [3:0] IDX_MODE_SUPPLY = 4'h0;
    localparam logic [3:0] IDX_BUS_ONE = 4'h3;

    // ------------------------------------------------------------------
    // Fields, codes and reset values
    // ------------------------------------------------------------------
    localparam int MODE_FIELD_LSB = 6;
    localparam int SEC_REG_FIELD_LSB = 3;
    localparam logic [7:0] SEC_REG_FIELD_MASK = 8'h18;
    localparam logic [1:0] MODE_CODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_CODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_CODE_STOP = 2'h2;
    localparam logic [1:0] MODE_CODE_RESTART = 2'h3;
    localparam int TRX_COUNT = 4;
    localparam logic [1:0] TRX_OFF = 2'h0;
    localparam logic [1:0] TRX_WAKE = 2'h1;
    localparam logic [1:0] TRX_ON = 2'h3;
    localparam ctrl_bank_t CTRL_BANK_RESET = '0;
    localparam stat_bank_t STAT_BANK_RESET = '0;
    localparam logic [10:0] PIN_SYNC_RESET = 11'h001;

endpackage : sbc_regmap_pkg

// ### rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module pin_sync
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
)
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Asynchronous pins in, filtered levels out
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
        end
        else if (ce)
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit only moves once the two late stages agree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            level <= INIT;
        end
        else if (ce)
        begin
            level <= (stage2 & stage3) | (level & (stage2 | stage3));
        end
    end

endmodule : pin_sync

`default_nettype wire

// ### rtl/sbc_spi_regbank.sv
// SPI-reached register bank of the system basis chip
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Control registers 01..1E read, bit 7 writes.
// - Written value shows only from the next command.
// - Status 41..7E read, bit 7 also clears 41..47 and 4C.
// - Wake level mirrors pins, clear ignored.
// - Mode field follows every actual mode change.
// - Sleep entry turns transceiver on into wake.
// - Triggered fail-safe output survives sleep entry.
// - Regulator field writable only in normal mode.
// - Transceiver off, on or wake per setting in init and normal; on gives wake in stop, off in restart and fail-safe.
// - Address bits 6..0, selector bit 7.
// - Data byte in bits 15..8, byte-wise.
// - Restart, sleep, fail-safe ignore SPI commands.
module sbc_spi_regbank
#(
    // Arbitrary value
    parameter logic [7:0] PRODUCT_ID = 8'h5A
)
(
    // Clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    // SPI pins
    input wire logic SPI_SEL_N,
    input wire logic SPI_CLK,
    input wire logic SPI_DI,
    output logic SPI_DO,
    output logic SPI_DO_OE_N,
    // Device state
    input wire sbc_regmap_pkg::op_mode_t OPERATING_MODE,
    input wire sbc_regmap_pkg::stat_bank_t STATUS_SET,
    input wire logic [7:0] WAKE_INPUT,
    input wire logic FAIL_SAFE_TRIGGER,
    // Register contents and derived controls
    output var sbc_regmap_pkg::ctrl_bank_t CONTROL,
    output var sbc_regmap_pkg::stat_bank_t STATUS,
    output logic SECONDARY_REGULATOR_ON,
    output logic [3:0] TRX_ACTIVE,
    output logic [3:0] TRX_WAKE_CAPABLE,
    output logic FAIL_SAFE_OUTPUT
);
    import sbc_regmap_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic reg_sel_t ctrl_sel(input logic [6:0] addr);
        reg_sel_t s;
        s.hit = 1'b1;
        s.idx = 4'h0;
        case (addr)
            ADDR_MODE_SUPPLY_CONTROL: s.idx = 4'h0;
            ADDR_HARDWARE_CONTROL: s.idx = 4'h1;
            ADDR_WATCHDOG_CONTROL: s.idx = 4'h2;
            ADDR_BUS_CONTROL_ONE: s.idx = 4'h3;
            ADDR_BUS_CONTROL_TWO: s.idx = 4'h4;
            ADDR_WAKE_CONTROL_ONE: s.idx = 4'h5;
            ADDR_WAKE_CONTROL_TWO: s.idx = 4'h6;
            ADDR_WAKE_PULL_CONTROL: s.idx = 4'h7;
            ADDR_CYCLIC_TIMER_CONTROL: s.idx = 4'h8;
            ADDR_SYSTEM_SCRATCH_CONTROL: s.idx = 4'h9;
            default: s.hit = 1'b0;
        endcase
        return s;
    endfunction : ctrl_sel

    // Only the clearable status registers; read-only ones miss here
    function automatic reg_sel_t stat_sel(input logic [6:0] addr);
        reg_sel_t s;
        s.hit = 1'b1;
        s.idx = 4'h0;
        case (addr)
            ADDR_SUPPLY_STATUS: s.idx = 4'h0;
            ADDR_THERMAL_STATUS: s.idx = 4'h1;
            ADDR_DEVICE_STATUS: s.idx = 4'h2;
            ADDR_BUS_STATUS_ONE: s.idx = 4'h3;
            ADDR_BUS_STATUS_TWO: s.idx = 4'h4;
            ADDR_WAKE_STATUS_ONE: s.idx = 4'h5;
            ADDR_WAKE_STATUS_TWO: s.idx = 4'h6;
            ADDR_SWITCHER_STATUS: s.idx = 4'h7;
            default: s.hit = 1'b0;
        endcase
        return s;
    endfunction : stat_sel

    function automatic logic [1:0] mode_code(input op_mode_t m);
        case (m)
            MODE_SLEEP: return MODE_CODE_SLEEP;
            MODE_STOP: return MODE_CODE_STOP;
            MODE_RESTART, MODE_FAIL_SAFE: return MODE_CODE_RESTART;
            default: return MODE_CODE_NORMAL;
        endcase
    endfunction : mode_code

    // ------------------------------------------------------------------
    // Pin synchronisation and edges
    // ------------------------------------------------------------------
    logic [10:0] pins;
    logic sel_n;
    logic sclk;
    logic sdi;
    logic [7:0] wake_level;
    logic sel_n_prev;
    logic sclk_prev;

    pin_sync #(.WIDTH(11), .INIT(PIN_SYNC_RESET)) u_pin_sync
    (
        .clk(CORE_CLK),
        .rst(RST),
        .ce(CE),
        .pin({WAKE_INPUT, SPI_DI, SPI_CLK, SPI_SEL_N}),
        .level(pins)
    );

    assign sel_n = pins[0];
    assign sclk = pins[1];
    assign sdi = pins[2];
    assign wake_level = pins[10:3];

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            sel_n_prev <= 1'b1;
            sclk_prev <= 1'b0;
        end
        else if (CE)
        begin
            sel_n_prev <= sel_n;
            sclk_prev <= sclk;
        end
    end

    logic frame_start;
    logic frame_stop;
    logic clk_fall;
    logic clk_rise;
    assign frame_start = sel_n_prev & ~sel_n;
    assign frame_stop = ~sel_n_prev & sel_n;
    assign clk_fall = ~sel_n & sclk_prev & ~sclk;
    assign clk_rise = ~sel_n & ~sclk_prev & sclk;

    // ------------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------------
    frame_state_t state;
    spi_frame_t rx;
    logic [4:0] bit_count;
    logic clk_edge_err;
    logic err_flag;
    logic [7:0] tx;
    logic ignore_mode;
    logic frame_ok;
    logic exec;
    reg_sel_t cmd_ctrl;
    reg_sel_t cmd_stat;
    logic [6:0] early_addr;
    logic [7:0] info_field;
    logic [7:0] resp_byte;

    assign ignore_mode = (OPERATING_MODE == MODE_RESTART) || (OPERATING_MODE == MODE_SLEEP)
        || (OPERATING_MODE == MODE_FAIL_SAFE);
    assign frame_ok = (bit_count == FRAME_BITS) && !clk_edge_err && !sclk;
    assign exec = (state == FR_END) && frame_ok && !ignore_mode;
    assign cmd_ctrl = ctrl_sel(rx.addr);
    assign cmd_stat = stat_sel(rx.addr);
    // After seven shifts the address sits in the top of the shifter
    assign early_addr = rx[15:9];

    always_comb
    begin
        info_field = '0;
        for (int i = 0; i < STAT_COUNT; i++)
        begin
            info_field[i] = |STATUS[i];
        end
    end

    // Control response shows the stored value, so a write shows next time
    always_comb
    begin
        reg_sel_t c;
        reg_sel_t s;
        c = ctrl_sel(early_addr);
        s = stat_sel(early_addr);
        resp_byte = 8'h00;
        if (c.hit)
        begin
            resp_byte = CONTROL[c.idx];
        end
        else if (s.hit)
        begin
            resp_byte = STATUS[s.idx];
        end
        else if (early_addr == ADDR_WAKE_LEVEL_STATUS)
        begin
            resp_byte = wake_level;
        end
        else if (early_addr == ADDR_PRODUCT_IDENTIFICATION)
        begin
            resp_byte = PRODUCT_ID;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= FR_IDLE;
        end
        else if (CE)
        begin
            case (state)
                FR_IDLE: state <= frame_start ? FR_SHIFT : FR_IDLE;
                FR_SHIFT: state <= frame_stop ? FR_END : FR_SHIFT;
                FR_END: state <= FR_IDLE;
                default: state <= FR_IDLE;
            endcase
        end
    end

    // Receive LSB first; bits 6..0 address, 7 selector, 15..8 data
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            rx <= '0;
            bit_count <= 5'h00;
        end
        else if (CE)
        begin
            if (frame_start)
            begin
                bit_count <= 5'h00;
            end
            else if (clk_fall)
            begin
                rx <= {sdi, rx[15:1]};
                if (bit_count != BIT_COUNT_MAX)
                begin
                    bit_count <= bit_count + 5'h01;
                end
            end
        end
    end

    // Clock high at either select edge spoils the frame
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            clk_edge_err <= 1'b0;
            err_flag <= 1'b0;
        end
        else if (CE)
        begin
            if (frame_start)
            begin
                clk_edge_err <= sclk;
            end
            if (state == FR_END)
            begin
                err_flag <= !frame_ok && (bit_count != 5'h00 || clk_edge_err || sclk);
            end
        end
    end

    // Error flag leads, then info field, then the addressed byte
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            tx <= 8'h00;
            SPI_DO <= 1'b0;
            SPI_DO_OE_N <= 1'b1;
        end
        else if (CE)
        begin
            if (frame_start)
            begin
                tx <= info_field;
                SPI_DO <= err_flag;
                SPI_DO_OE_N <= 1'b0;
            end
            else if (frame_stop)
            begin
                SPI_DO_OE_N <= 1'b1;
            end
            else if (clk_fall && bit_count == HALF_FRAME_BITS - 5'h01)
            begin
                tx <= resp_byte;
            end
            else if (clk_rise)
            begin
                SPI_DO <= tx[0];
                tx <= {1'b0, tx[7:1]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    op_mode_t mode_prev;
    logic mode_change;
    logic [7:0] next_mode_supply;
    ctrl_bank_t next_control;

    assign mode_change = (OPERATING_MODE != mode_prev);

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            mode_prev <= MODE_INIT;
        end
        else if (CE)
        begin
            mode_prev <= OPERATING_MODE;
        end
    end

    always_comb
    begin
        next_control = CONTROL;
        if (exec && rx.rw && cmd_ctrl.hit)
        begin
            next_control[cmd_ctrl.idx] = rx.data;
            if (cmd_ctrl.idx == IDX_MODE_SUPPLY && OPERATING_MODE != MODE_NORMAL)
            begin
                next_control[IDX_MODE_SUPPLY] = (rx.data & ~SEC_REG_FIELD_MASK)
                    | (CONTROL[IDX_MODE_SUPPLY] & SEC_REG_FIELD_MASK);
            end
        end
        next_mode_supply = next_control[IDX_MODE_SUPPLY];
        if (mode_change)
        begin
            next_mode_supply[MODE_FIELD_LSB +: 2] = mode_code(OPERATING_MODE);
            if (OPERATING_MODE == MODE_SLEEP)
            begin
                for (int t = 0; t < TRX_COUNT; t++)
                begin
                    if (next_control[IDX_BUS_ONE][2*t +: 2] == TRX_ON)
                    begin
                        next_control[IDX_BUS_ONE][2*t +: 2] = TRX_WAKE;
                    end
                end
            end
        end
        next_control[IDX_MODE_SUPPLY] = next_mode_supply;
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            CONTROL <= CTRL_BANK_RESET;
        end
        else if (CE)
        begin
            CONTROL <= next_control;
        end
    end

    // ------------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------------
    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            STATUS <= STAT_BANK_RESET;
        end
        else if (CE)
        begin
            for (int i = 0; i < STAT_COUNT; i++)
            begin
                if (exec && rx.rw && cmd_stat.hit && cmd_stat.idx == 4'(i))
                begin
                    STATUS[i] <= STATUS_SET[i];
                end
                else
                begin
                    STATUS[i] <= STATUS[i] | STATUS_SET[i];
                end
            end
        end
    end
    // Wake level and identity are not in the clearable decode

    // ------------------------------------------------------------------
    // Derived controls
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            TRX_ACTIVE <= 4'h0;
            TRX_WAKE_CAPABLE <= 4'h0;
            SECONDARY_REGULATOR_ON <= 1'b0;
        end
        else if (CE)
        begin
            for (int t = 0; t < TRX_COUNT; t++)
            begin
                TRX_ACTIVE[t] <= (CONTROL[IDX_BUS_ONE][2*t +: 2] == TRX_ON)
                    && (OPERATING_MODE == MODE_NORMAL || OPERATING_MODE == MODE_INIT);
                TRX_WAKE_CAPABLE[t] <= (CONTROL[IDX_BUS_ONE][2*t +: 2] == TRX_WAKE)
                    || ((CONTROL[IDX_BUS_ONE][2*t +: 2] == TRX_ON)
                    && OPERATING_MODE == MODE_STOP);
            end
            // Regulator may run in stop and sleep; its diagnosis stays live
            SECONDARY_REGULATOR_ON <= |CONTROL[IDX_MODE_SUPPLY][SEC_REG_FIELD_LSB +: 2];
        end
    end

    // Mode changes never release a triggered fail-safe output
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            FAIL_SAFE_OUTPUT <= 1'b0;
        end
        else if (CE && FAIL_SAFE_TRIGGER)
        begin
            FAIL_SAFE_OUTPUT <= 1'b1;
        end
    end

endmodule : sbc_spi_regbank

`default_nettype wire

// ### bench/sbc_spi_regbank_props.sv
// Port checks of the SPI register bank
`timescale 1ns/10ps
`default_nettype none

module sbc_spi_regbank_props
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Watched ports
    input wire logic SPI_SEL_N,
    input wire logic SPI_DO_OE_N,
    input wire sbc_regmap_pkg::op_mode_t OPERATING_MODE,
    input wire sbc_regmap_pkg::stat_bank_t STATUS_SET,
    input wire logic FAIL_SAFE_TRIGGER,
    input wire sbc_regmap_pkg::ctrl_bank_t CONTROL,
    input wire sbc_regmap_pkg::stat_bank_t STATUS,
    input wire logic FAIL_SAFE_OUTPUT
);
    import sbc_regmap_pkg::*;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    function automatic logic [1:0] code_of(op_mode_t m);
        case (m)
            MODE_SLEEP: return MODE_CODE_SLEEP;
            MODE_STOP: return MODE_CODE_STOP;
            MODE_RESTART, MODE_FAIL_SAFE: return MODE_CODE_RESTART;
            default: return MODE_CODE_NORMAL;
        endcase
    endfunction : code_of

    function automatic logic any_on(logic [7:0] b);
        return b[1:0] == TRX_ON || b[3:2] == TRX_ON || b[5:4] == TRX_ON || b[7:6] == TRX_ON;
    endfunction : any_on

    // ------------
    // Mode events
    // ------------
    sequence s_mode_step;
        $changed(OPERATING_MODE) ##1 $stable(OPERATING_MODE);
    endsequence
    sequence s_sleep_entry;
        OPERATING_MODE == MODE_SLEEP && $past(OPERATING_MODE) != MODE_SLEEP;
    endsequence

    a_mode_field_follows: assert property (s_mode_step
        |-> CONTROL[0][7:6] == code_of(OPERATING_MODE))
        else $error("mode field stale");
    a_sleep_trx_wake: assert property (s_sleep_entry |=> !any_on(CONTROL[IDX_BUS_ONE]))
        else $error("trx on in sleep");
    a_failsafe_set: assert property (FAIL_SAFE_TRIGGER |-> ##[1:2] FAIL_SAFE_OUTPUT)
        else $error("fs not set");
    a_failsafe_sticky: assert property (FAIL_SAFE_OUTPUT |=> FAIL_SAFE_OUTPUT)
        else $error("fs dropped");
    a_regulator_locked: assert property (OPERATING_MODE != MODE_NORMAL
        && $past(OPERATING_MODE) != MODE_NORMAL |-> $stable(CONTROL[0][4:3]))
        else $error("reg field moved");
    // Set wins; idle never clears
    a_status_set_wins: assert property ((STATUS & $past(STATUS_SET)) == $past(STATUS_SET))
        else $error("set bit lost");
    a_status_hold: assert property (SPI_SEL_N [*8]
        |-> (STATUS & $past(STATUS)) == $past(STATUS))
        else $error("idle clear");
    a_out_released: assert property (SPI_SEL_N [*7] |-> SPI_DO_OE_N)
        else $error("out on idle");
    a_out_driven: assert property (!SPI_SEL_N [*7] |-> !SPI_DO_OE_N)
        else $error("out off in frame");
endmodule : sbc_spi_regbank_props
`default_nettype wire

// ### bench/spi_master_model.sv
// Behavioural SPI master model
`timescale 1ns/10ps
`default_nettype none

module spi_master_model
#(
    parameter int HALF = 8,
    parameter int GAP = 12
)
(
    // Clock
    input wire logic clk,
    // SPI lines
    output logic sel_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo
);
    initial
    begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // LSB first; r[0] error, r[8:1] info, r[16:9] data
    task automatic frame(input logic [15:0] w, input int nb, output logic [16:0] r);
        @(posedge clk);
        sel_n <= 1'b0;
        repeat (HALF) @(posedge clk);
        for (int i = 0; i < nb; i++)
        begin
            r[i] = sdo;
            sclk <= 1'b1;
            sdi <= w[i];
            repeat (HALF) @(posedge clk);
            sclk <= 1'b0;
            repeat (HALF) @(posedge clk);
        end
        r[nb] = sdo;
        sel_n <= 1'b1;
        // Released line shows the inverse
        sdi <= ~sdi;
        repeat (GAP) @(posedge clk);
    endtask : frame
endmodule : spi_master_model
`default_nettype wire

// ### bench/sbc_spi_register_map_test.sv
// Bench for the SPI register bank
`timescale 1ns/10ps
`default_nettype none

module sbc_spi_register_map_test;
    import sbc_regmap_pkg::*;

    // Arbitrary ID value
    localparam logic [7:0] TEST_ID = 8'h3C;
    localparam int LIMIT = 40000;
    localparam logic [6:0] CTRL_ADDR [CTRL_COUNT] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
        7'h06, 7'h07, 7'h08, 7'h0C, 7'h1E};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic sel_n, sclk, sdi, sdo, sdo_oe_n, reg_on, fs_out;
    op_mode_t op_mode = MODE_NORMAL;
    stat_bank_t status_set = '0;
    logic [7:0] wake_in = 8'h00;
    logic fs_trig = 1'b0;
    ctrl_bank_t control;
    stat_bank_t status;
    logic [3:0] trx_act, trx_wake;
    logic [16:0] r;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;

    always #2 core_clk = ~core_clk;

    sbc_spi_regbank #(.PRODUCT_ID(TEST_ID)) sbc_spi_regbank_inst
    (
        .CORE_CLK(core_clk), .RST(rst), .CE(1'b1), .SPI_SEL_N(sel_n), .SPI_CLK(sclk),
        .SPI_DI(sdi), .SPI_DO(sdo), .SPI_DO_OE_N(sdo_oe_n), .OPERATING_MODE(op_mode),
        .STATUS_SET(status_set), .WAKE_INPUT(wake_in), .FAIL_SAFE_TRIGGER(fs_trig),
        .CONTROL(control), .STATUS(status), .SECONDARY_REGULATOR_ON(reg_on),
        .TRX_ACTIVE(trx_act), .TRX_WAKE_CAPABLE(trx_wake), .FAIL_SAFE_OUTPUT(fs_out)
    );
    spi_master_model spi_master_model_inst
    (
        .clk(core_clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo)
    );

    // ------------
    // Shared tasks
    // ------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic xfer(input logic [6:0] a, input logic rw, input logic [7:0] d);
        spi_master_model_inst.frame({d, rw, a}, 16, r);
    endtask : xfer

    task automatic set_mode(input op_mode_t m);
        @(posedge core_clk);
        op_mode <= m;
        repeat (3) @(posedge core_clk);
    endtask : set_mode

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // ------------
    // Scenarios
    // ------------
    task automatic test_control();
        logic [7:0] v;
        for (int i = 0; i < CTRL_COUNT; i++)
        begin
            v = 8'(8'h11 * (i + 1));
            xfer(CTRL_ADDR[i], 1'b1, v);
            check("ctrl old", 16'(r[16:9]), 16'h0000);
            xfer(CTRL_ADDR[i], 1'b0, 8'hFF);
            check("ctrl read", 16'(r[16:9]), 16'(v));
            check("ctrl port", 16'(control[i]), 16'(v));
        end
        $display("control done");
    endtask : test_control

    task automatic test_status();
        @(posedge core_clk);
        status_set[1] <= 8'h24;
        wake_in <= 8'hC3;
        @(posedge core_clk);
        status_set[1] <= 8'h00;
        xfer(ADDR_THERMAL_STATUS, 1'b0, 8'h00);
        check("stat read", r[16:1], 16'h2402);
        check("stat kept", 16'(status[1]), 16'h0024);
        xfer(ADDR_THERMAL_STATUS, 1'b1, 8'h00);
        check("clr resp", r[16:1], 16'h2402);
        check("cleared", 16'(status[1]), 16'h0000);
        xfer(ADDR_WAKE_LEVEL_STATUS, 1'b1, 8'h00);
        check("info clr", 16'(r[8:1]), 16'h0000);
        xfer(ADDR_WAKE_LEVEL_STATUS, 1'b0, 8'h00);
        check("wake level", 16'(r[16:9]), 16'h00C3);
        xfer(ADDR_PRODUCT_IDENTIFICATION, 1'b1, 8'hFF);
        xfer(ADDR_PRODUCT_IDENTIFICATION, 1'b0, 8'h00);
        check("id", 16'(r[16:9]), 16'(TEST_ID));
        xfer(7'h10, 1'b0, 8'h00);
        check("unmap", 16'(r[16:9]), 16'h0000);
        $display("status done");
    endtask : test_status

    task automatic test_error();
        spi_master_model_inst.frame({8'h55, 1'b1, ADDR_SYSTEM_SCRATCH_CONTROL}, 8, r);
        xfer(ADDR_SYSTEM_SCRATCH_CONTROL, 1'b0, 8'h00);
        check("err flag", 16'(r[0]), 16'h0001);
        check("short", 16'(r[16:9]), 16'h00AA);
        xfer(ADDR_SYSTEM_SCRATCH_CONTROL, 1'b0, 8'h00);
        check("err clr", 16'(r[0]), 16'h0000);
        $display("error done");
    endtask : test_error

    task automatic test_modes();
        xfer(ADDR_BUS_CONTROL_ONE, 1'b1, 8'hF3);
        xfer(ADDR_MODE_SUPPLY_CONTROL, 1'b1, 8'h08);
        @(posedge core_clk);
        fs_trig <= 1'b1;
        @(posedge core_clk);
        fs_trig <= 1'b0;
        set_mode(MODE_STOP);
        check("stop code", 16'(control[0][7:6]), 16'(MODE_CODE_STOP));
        xfer(ADDR_MODE_SUPPLY_CONTROL, 1'b1, 8'h00);
        check("reg locked", 16'(control[0][4:3]), 16'h0001);
        check("stop act", 16'(trx_act), 16'h0000);
        check("stop wake", 16'(trx_wake), 16'h000D);
        set_mode(MODE_SLEEP);
        check("sleep code", 16'(control[0][7:6]), 16'(MODE_CODE_SLEEP));
        check("sleep trx", 16'(control[3]), 16'h0051);
        xfer(ADDR_SYSTEM_SCRATCH_CONTROL, 1'b1, 8'h77);
        check("sleep ign", 16'(control[9]), 16'h00AA);
        set_mode(MODE_RESTART);
        set_mode(MODE_NORMAL);
        check("norm code", 16'(control[0][7:6]), 16'(MODE_CODE_NORMAL));
        check("fs kept", 16'(fs_out), 16'h0001);
        check("reg on", 16'(reg_on), 16'h0001);
        check("norm act", 16'(trx_act), 16'h0000);
        check("norm wake", 16'(trx_wake), 16'h000D);
        $display("modes done");
    endtask : test_modes

    initial
    begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        test_control();
        test_status();
        test_error();
        test_modes();
        finish_test();
    end

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            err_total++;
            finish_test();
        end
    end
endmodule : sbc_spi_register_map_test

bind sbc_spi_regbank sbc_spi_regbank_props sbc_spi_regbank_props_inst
(
    .CORE_CLK(CORE_CLK), .RST(RST), .SPI_SEL_N(SPI_SEL_N), .SPI_DO_OE_N(SPI_DO_OE_N),
    .OPERATING_MODE(OPERATING_MODE), .STATUS_SET(STATUS_SET),
    .FAIL_SAFE_TRIGGER(FAIL_SAFE_TRIGGER), .CONTROL(CONTROL), .STATUS(STATUS),
    .FAIL_SAFE_OUTPUT(FAIL_SAFE_OUTPUT)
);
`default_nettype wire
